// [core/mbarb_edge.sv]
/*
  Edge finder for a clock pin that has already been synchronised.
  Assumes the input is stable in the system clock domain; outputs are pulses.
*/
`timescale 1ns/1ps
module mbarb_edge (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  output logic o_rise,
  output logic o_fall
);

  typedef struct packed {
    logic prev;
  } mbarb_edge_t;

  mbarb_edge_t st;
  mbarb_edge_t next_st;

  // Remember the last level to compare against.
  always_comb begin
    next_st.prev = i_level;
  end

  // Resetting high means a high pin yields no spurious rise.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st.prev <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  // One-cycle pulses on each detected edge.
  assign o_rise = i_level & ~st.prev;
  assign o_fall = ~i_level & st.prev;

endmodule : mbarb_edge

// [core/mbarb_sync.sv]
/*
  Two flip-flop synchroniser for a group of pins from outside the system clock.
  Assumes a synchronous active-high reset and bits that change independently.
*/
`timescale 1ns/1ps
module mbarb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mbarb_sync_t;

  mbarb_sync_t st;
  mbarb_sync_t next_st;

  // The first stage feeds only the second stage, never any logic.
  always_comb begin
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
  end

  // Reset loads RST_VAL; a pin at another level at release gives one false edge after it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st.s1 <= RST_VAL;
      st.s2 <= RST_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.s2;

endmodule : mbarb_sync

// [core/mbarb_top.sv]
/*
  Multi-master bus arbiter control slice: request and surrender decisions from
  processor status, straps and select, the wired busy and common request
  lines, the latch tri-state control, and a small AHB-Lite register slave.
  Assumes every arbiter pin arrives from outside the 200 MHz system clock and
  that the pad logic resolves the open-drain wires from the output enables.
  //Operation
  //[R1] I/O strap: decide from status bit two
  //[R2] I/O mode: request on memory commands
  //[R3] I/O mode: surrender allowed during I/O
  //[R4] Interrupt acknowledge treated as I/O
  //[R5] Drive latch tri-state control output
  //[R6] Init input low resets arbiter state
  //[R7] After init no arbiter owns bus
  //[R8] Select used only with resident strap
  //[R9] Resident mode: request while select high
  //[R10] Resident mode: surrender while select low
  //[R11] Select may glitch from T4 to T2
  //[R12] Select clean from T2 to T4
  //[R13] Common request low means lower requester
  //[R14] Common request line is open-drain wired
  //[R15] Transfer owner never pulls common request
  //[R16] Owner drops request and surrenders when allowed
  //[R17] Tied request plus any-strap: surrender each cycle
  //[R18] Bus pins synchronised to bus clock
  //[R19] Priority in lets take bus next fall
  //[R20] Winner pulls busy low, releases when done
  //[R21] Lock low forbids any surrender
  //[R22] Without bus, latch drivers held floating
  //[R23] Status bit two low: I/O, high: memory
*/
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "mbarb_defines.svh"
module mbarb_top (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  input wire logic I_PROC_CLK,
  input wire logic [2:0] I_STATUS_N,
  input wire logic I_LOCK_N,
  input wire logic I_COMMON_REQUEST_LOCK_N,
  input wire logic I_RESIDENT_MODE_STRAP,
  input wire logic I_IO_BUS_STRAP_N,
  input wire logic I_ANY_REQUEST_STRAP,
  input wire logic I_SYSTEM_BUS_SELECT,
  input wire logic I_INIT_N,
  input wire logic I_BUS_CLK,
  input wire logic I_PRIORITY_IN_N,
  input wire logic I_COMMON_REQUEST_LINE,
  output logic O_COMMON_REQUEST_LINE,
  output logic O_COMMON_REQUEST_LINE_OE,
  input wire logic I_BUSY_N,
  output logic O_BUSY_N,
  output logic O_BUSY_N_OE,
  output logic O_BUS_REQUEST_OUT_N,
  output logic O_PRIORITY_OUT_N,
  output logic O_LATCH_TRISTATE_CTL_N
);

  mbarb_pkg::mbarb_state_t st;
  mbarb_pkg::mbarb_state_t next_st;

  logic [`MBARB_PIN_COUNT-1:0] pins_raw;
  logic [`MBARB_PIN_COUNT-1:0] pins;
  logic [2:0] status_n;
  logic lock_n;
  logic crqlck_n;
  logic res_mode;
  logic io_bus_strap_n;
  logic any_req;
  logic sys_sel;
  logic init_n;
  logic bus_clk_s;
  logic prio_in_n;
  logic common_request_line_in;
  logic busy_in_n;
  logic proc_clk_s;
  logic proc_rise;
  logic bclk_fall;
  logic need;
  logic permit;
  logic demand;
  logic [31:0] rd_val;
  logic addr_phase;

  // Every arbiter pin crosses into the system clock through two flops.
  assign pins_raw = {I_STATUS_N, I_LOCK_N, I_COMMON_REQUEST_LOCK_N, I_IO_BUS_STRAP_N,
                     I_ANY_REQUEST_STRAP, I_SYSTEM_BUS_SELECT, I_PRIORITY_IN_N,
                     I_COMMON_REQUEST_LINE, I_BUSY_N, I_RESIDENT_MODE_STRAP, I_INIT_N};

  mbarb_sync #(
    .W(`MBARB_PIN_COUNT),
    .RST_VAL(`MBARB_SYNC_RST)
  ) u_pin_sync (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_d(pins_raw),
    .o_q(pins)
  );

  // Both clocks are sampled as data; the bus clock fall and the processor clock rise come out as enable pulses.
  mbarb_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_clk_sync (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_d({I_BUS_CLK, I_PROC_CLK}),
    .o_q({bus_clk_s, proc_clk_s})
  );

  // The bus clock runs free, so the one fall seen right after reset is harmless:
  // init leaves its synchroniser in that same cycle, and outside resident mode no request is pending yet.
  mbarb_edge u_bus_edge (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_level(bus_clk_s),
    .o_rise(),
    .o_fall(bclk_fall)
  );

  mbarb_edge u_proc_edge (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_level(proc_clk_s),
    .o_rise(proc_rise),
    .o_fall()
  );

  // Unpack the synchronised pins; the order matches the concatenation above.
  assign status_n = pins[12:10];
  assign lock_n = pins[9];
  assign crqlck_n = pins[8];
  assign io_bus_strap_n = pins[7];
  assign any_req = pins[6];
  assign sys_sel = pins[5];
  assign prio_in_n = pins[4];
  assign common_request_line_in = pins[3];
  assign busy_in_n = pins[2];
  assign res_mode = pins[1];
  assign init_n = pins[0];

  // Request and surrender conditions per strap mode.
  always_comb begin
    if (res_mode) begin
      need = sys_sel;  // [R8] [R9]
      permit = ~sys_sel;  // [R10]
    end else if (!io_bus_strap_n) begin
      need = st.cyc_active & st.mem_cycle;  // [R1] [R2]
      permit = ~need;  // [R3] [R4]
    end else begin
      need = st.cyc_active & ~st.halt;
      permit = ~st.cyc_active;
    end
    need = need & st.ctrl_en;
    // Common request low means someone below us wants the bus. Without the
    // any-request strap we only yield to it between transfers.
    demand = prio_in_n | st.halt | (~common_request_line_in & crqlck_n & (any_req | ~st.cyc_active));  // [R13] [R17]
  end

  // Register read mux; a pending control write is forwarded so control reads never lag.
  always_comb begin
    rd_val = `MBARB_ZERO_WORD;
    case (I_HADDR[`MBARB_ADDR_MSB:0])
      `MBARB_ADDR_CTRL: begin
        rd_val[`MBARB_CTRL_EN_BIT] = (st.wr_pend & st.wr_ctrl) ? I_HWDATA[`MBARB_CTRL_EN_BIT] : st.ctrl_en;
      end
      `MBARB_ADDR_STAT: begin
        rd_val[`MBARB_STAT_OWN_BIT] = (st.fsm == mbarb_pkg::MBARB_OWN);
        rd_val[`MBARB_STAT_REQ_BIT] = (st.fsm == mbarb_pkg::MBARB_REQ);
        rd_val[`MBARB_STAT_CYC_BIT] = st.cyc_active;
        rd_val[`MBARB_STAT_NEED_BIT] = need;
        rd_val[`MBARB_STAT_INIT_BIT] = ~init_n;
      end
      default: begin
        rd_val = `MBARB_ZERO_WORD;
      end
    endcase
  end

  // An address phase is taken only while the bus is ready.
  assign addr_phase = I_HSEL & I_HTRANS[`MBARB_HTRANS_ACTIVE_BIT] & I_HREADY;

  // All next-state logic of the slice in one place.
  always_comb begin
    next_st = st;
    next_st.hready = 1'h1;
    next_st.lvl_zero = 1'h0;  // [R14]
    // Bus slave: zero wait states, a write lands in its data phase.
    if (st.wr_pend && st.wr_ctrl) begin
      next_st.ctrl_en = I_HWDATA[`MBARB_CTRL_EN_BIT];
    end
    next_st.wr_pend = addr_phase & I_HWRITE;
    next_st.wr_ctrl = I_HADDR[`MBARB_ADDR_MSB:0] == `MBARB_ADDR_CTRL;
    if (addr_phase && !I_HWRITE) begin
      next_st.hrdata = rd_val;
    end
    // Processor cycle tracking is clocked by the processor clock edge.
    if (proc_rise) begin
      next_st.cyc_active = status_n != `MBARB_STATUS_PASSIVE;
      next_st.mem_cycle = status_n[`MBARB_S2_BIT];  // [R23]
      next_st.halt = status_n == `MBARB_STATUS_HALT;
    end
    // Shared-bus pins move on the falling bus clock edge, or at once while init is low.
    if (bclk_fall) begin  // [R18]
      case (st.fsm)
        mbarb_pkg::MBARB_IDLE: begin
          if (need) begin
            next_st.fsm = mbarb_pkg::MBARB_REQ;
            next_st.bus_request_out_n = 1'h0;
          end
        end
        mbarb_pkg::MBARB_REQ: begin
          if (!need) begin
            next_st.fsm = mbarb_pkg::MBARB_IDLE;
            next_st.bus_request_out_n = 1'h1;
          end else if (!prio_in_n && busy_in_n) begin
            next_st.fsm = mbarb_pkg::MBARB_OWN;  // [R19]
            next_st.busy_oe = 1'h1;  // [R20]
            next_st.aen_n = 1'h0;  // [R5]
          end
        end
        mbarb_pkg::MBARB_OWN: begin
          if (lock_n && permit && demand) begin  // [R21]
            next_st.fsm = mbarb_pkg::MBARB_IDLE;
            next_st.bus_request_out_n = 1'h1;  // [R16]
            next_st.busy_oe = 1'h0;  // [R20]
            next_st.aen_n = 1'h1;  // [R22]
          end
        end
        default: begin
          next_st.fsm = mbarb_pkg::MBARB_IDLE;
        end
      endcase
      // Only a waiting arbiter pulls the common line; the owner never does.
      next_st.common_request_line_oe = next_st.fsm == mbarb_pkg::MBARB_REQ;  // [R15]
      next_st.prio_out_n = prio_in_n | (next_st.fsm != mbarb_pkg::MBARB_IDLE);
    end
    // Init acts at once, not at a bus edge, so it also clears a stuck owner.
    if (!init_n) begin  // [R6]
      next_st.fsm = mbarb_pkg::MBARB_IDLE;  // [R7]
      next_st.bus_request_out_n = 1'h1;
      next_st.busy_oe = 1'h0;
      next_st.common_request_line_oe = 1'h0;
      next_st.aen_n = 1'h1;
      next_st.prio_out_n = 1'h1;
    end
  end

  // Single state register; reset leaves the arbiter off the shared bus.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      st.fsm <= mbarb_pkg::MBARB_IDLE;
      st.cyc_active <= 1'h0;
      st.mem_cycle <= 1'h0;
      st.halt <= 1'h0;
      st.bus_request_out_n <= 1'h1;
      st.busy_oe <= 1'h0;
      st.common_request_line_oe <= 1'h0;
      st.prio_out_n <= 1'h1;
      st.aen_n <= 1'h1;
      st.ctrl_en <= `MBARB_CTRL_RST;
      st.wr_pend <= 1'h0;
      st.wr_ctrl <= 1'h0;
      st.hready <= 1'h1;
      st.lvl_zero <= 1'h0;
      st.hrdata <= `MBARB_ZERO_WORD;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign O_HREADYOUT = st.hready;
  assign O_HRESP = st.lvl_zero;
  assign O_HRDATA = st.hrdata;
  assign O_COMMON_REQUEST_LINE = st.lvl_zero;  // [R14]
  assign O_COMMON_REQUEST_LINE_OE = st.common_request_line_oe;
  assign O_BUSY_N = st.lvl_zero;
  assign O_BUSY_N_OE = st.busy_oe;
  assign O_BUS_REQUEST_OUT_N = st.bus_request_out_n;
  assign O_PRIORITY_OUT_N = st.prio_out_n;
  assign O_LATCH_TRISTATE_CTL_N = st.aen_n;  // [R5] [R22]

  // Checks on the arbitration behaviour.
  // The wired pins are constant zero, so only their enables ever move.
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);

  // Grant and surrender steps, as the state machine takes them on a bus fall.
  sequence s_grant_cond;
    bclk_fall && st.fsm == mbarb_pkg::MBARB_REQ && need && !prio_in_n && busy_in_n && init_n;
  endsequence

  sequence s_surrender_cond;
    bclk_fall && st.fsm == mbarb_pkg::MBARB_OWN && lock_n && permit && demand && init_n;
  endsequence

  a_init_clears_owner: assert property (!init_n |=> !O_BUSY_N_OE && O_LATCH_TRISTATE_CTL_N)  // [R6] [R7]
    else $error("init did not clear bus ownership");

  a_grant_takes_bus: assert property (s_grant_cond |=> O_BUSY_N_OE && !O_LATCH_TRISTATE_CTL_N)  // [R19] [R20]
    else $error("grant did not seize busy line");

  a_owner_no_common_request_line: assert property (O_BUSY_N_OE |-> !O_COMMON_REQUEST_LINE_OE)  // [R15]
    else $error("owner pulls common request line");

  a_wired_low_only: assert property (O_COMMON_REQUEST_LINE == 1'b0 && O_BUSY_N == 1'b0)  // [R14]
    else $error("open-drain pin drives high");

  a_lock_holds_bus: assert property (st.fsm == mbarb_pkg::MBARB_OWN && !lock_n && init_n
                                     |=> st.fsm == mbarb_pkg::MBARB_OWN)  // [R21]
    else $error("bus surrendered under lock");

  a_surrender_drops: assert property (s_surrender_cond |=> O_BUS_REQUEST_OUT_N && !O_BUSY_N_OE)  // [R16]
    else $error("surrender did not drop request and busy");

  a_aen_tracks_own: assert property ($fell(O_BUSY_N_OE)
                                     |-> O_LATCH_TRISTATE_CTL_N && ($past(bclk_fall) || !$past(init_n)))  // [R22]
    else $error("latches left enabled after losing bus");

  a_bus_edge_sync: assert property ($changed(O_BUS_REQUEST_OUT_N) |-> $past(bclk_fall) || !$past(init_n))  // [R18]
    else $error("bus request moved off bus clock edge");

  a_resident_request: assert property (res_mode && sys_sel && st.ctrl_en && st.fsm == mbarb_pkg::MBARB_IDLE
                                       && bclk_fall && init_n |=> !O_BUS_REQUEST_OUT_N)  // [R9]
    else $error("resident select high did not request");

  a_io_cycle_no_need: assert property (!res_mode && !io_bus_strap_n && !st.mem_cycle |-> !need)  // [R1] [R4]
    else $error("I/O cycle requested the bus in I/O mode");

endmodule : mbarb_top

// [inc/mbarb_defines.svh]
/*
  Constants for the multi-master bus arbiter slice: register offsets, field
  positions, reset values and processor status codes.
  Assumes it is included by bare name wherever these names are needed.
*/
`ifndef MBARB_DEFINES_SVH
`define MBARB_DEFINES_SVH

// Register byte offsets, decoded on the low address byte.
`define MBARB_ADDR_CTRL 8'h00
`define MBARB_ADDR_STAT 8'h04
`define MBARB_ADDR_MSB 7

// Control register fields and reset value.
`define MBARB_CTRL_EN_BIT 0
`define MBARB_CTRL_RST 1'h1

// Status register field positions.
`define MBARB_STAT_OWN_BIT 0
`define MBARB_STAT_REQ_BIT 1
`define MBARB_STAT_CYC_BIT 2
`define MBARB_STAT_NEED_BIT 3
`define MBARB_STAT_INIT_BIT 4

// Processor status codes, active low lines sampled as a 3-bit word.
`define MBARB_STATUS_PASSIVE 3'h7
`define MBARB_STATUS_HALT 3'h3
`define MBARB_S2_BIT 2

// Synchroniser reset value: all pins idle high, except init which reads active.
`define MBARB_SYNC_RST 13'h1FFE
`define MBARB_PIN_COUNT 13

// Fixed bus answers.
`define MBARB_ZERO_WORD 32'h0000_0000
`define MBARB_HTRANS_ACTIVE_BIT 1

`endif

// [inc/mbarb_pkg.sv]
/*
  Types of the multi-master bus arbiter slice: the arbitration state enum and
  the packed state record of the top module.
  Assumes the constants header is compiled alongside; no imports are used.
*/
package mbarb_pkg;

  // Arbitration states: idle, requesting the shared bus, owning it.
  typedef enum logic [1:0] {
    MBARB_IDLE,
    MBARB_REQ,
    MBARB_OWN
  } mbarb_fsm_t;

  // Whole state of the top module, registered in one process.
  typedef struct packed {
    mbarb_fsm_t fsm;
    logic cyc_active;
    logic mem_cycle;
    logic halt;
    logic bus_request_out_n;
    logic busy_oe;
    logic common_request_line_oe;
    logic prio_out_n;
    logic aen_n;
    logic ctrl_en;
    logic wr_pend;
    logic wr_ctrl;
    logic hready;
    logic lvl_zero;
    logic [31:0] hrdata;
  } mbarb_state_t;

endpackage : mbarb_pkg

// [sim/mbarb_peer.sv]
/*
  Behavioural peer arbiters on the shared bus: one of higher priority that
  withholds priority and seizes busy, one of lower priority on the common request.
  Assumes the bench resolves both open-drain wires from every enable.
*/
`timescale 1ns/1ps
module mbarb_peer (
  input wire logic i_bus_clk,
  input wire logic i_want_hi,
  input wire logic i_want_lo,
  input wire logic i_busy_wire,
  output logic o_prio_in_n,
  output logic o_busy_oe,
  output logic o_common_request_line_oe
);
  initial begin
    o_prio_in_n = 1'b0;
    o_busy_oe = 1'b0;
    o_common_request_line_oe = 1'b0;
  end

  // Peer pins move on bus clock falls only, like any real arbiter would.
  always @(negedge i_bus_clk) begin
    o_prio_in_n <= i_want_hi;
    o_busy_oe <= i_want_hi & (o_busy_oe | i_busy_wire);
    o_common_request_line_oe <= i_want_lo;
  end
endmodule : mbarb_peer

// [sim/mbarb_top_tb.sv]
/*
  Self-checking bench of the arbiter slice: AHB-Lite register tasks, processor
  cycle tasks and arbitration scenarios against a peer model.
  Assumes the design answers with zero wait states and acts on bus clock falls.
*/
`timescale 1ns/1ps
module mbarb_top_tb;
  logic clk = 1'b0, rst = 1'b1, bclk = 1'b0, pclk = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [2:0] status_n = 3'h7;
  logic lock_n = 1'b1, resident = 1'b0, io_n = 1'b1, any_rq = 1'b1, sel = 1'b0, init_n = 1'b1;
  logic want_hi = 1'b0, want_lo = 1'b0, prio_n, p_busy_oe, p_common_request_line_oe;
  logic common_request_line_o, common_request_line_oe, busy_o, busy_oe, bus_request_out_n, prio_out_n, aen_n, common_request_line_w, busy_w;
  int errors = 0;
  int cmp_count = 0;

  always #2.5 clk = ~clk;
  always #80 bclk = ~bclk;

  // Both wires have pull-ups; any party's enable pulls them low.
  assign common_request_line_w = ~(common_request_line_oe | p_common_request_line_oe);
  assign busy_w = ~(busy_oe | p_busy_oe);

  mbarb_top u_mbarb_top (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata), .I_PROC_CLK(pclk),
    .I_STATUS_N(status_n), .I_LOCK_N(lock_n), .I_COMMON_REQUEST_LOCK_N(1'b1),
    .I_RESIDENT_MODE_STRAP(resident), .I_IO_BUS_STRAP_N(io_n), .I_ANY_REQUEST_STRAP(any_rq),
    .I_SYSTEM_BUS_SELECT(sel), .I_INIT_N(init_n), .I_BUS_CLK(bclk), .I_PRIORITY_IN_N(prio_n),
    .I_COMMON_REQUEST_LINE(common_request_line_w), .O_COMMON_REQUEST_LINE(common_request_line_o),
    .O_COMMON_REQUEST_LINE_OE(common_request_line_oe), .I_BUSY_N(busy_w), .O_BUSY_N(busy_o),
    .O_BUSY_N_OE(busy_oe), .O_BUS_REQUEST_OUT_N(bus_request_out_n), .O_PRIORITY_OUT_N(prio_out_n),
    .O_LATCH_TRISTATE_CTL_N(aen_n));

  mbarb_peer u_mbarb_peer (.i_bus_clk(bclk), .i_want_hi(want_hi), .i_want_lo(want_lo),
    .i_busy_wire(busy_w), .o_prio_in_n(prio_n), .o_busy_oe(p_busy_oe), .o_common_request_line_oe(p_common_request_line_oe));

  task stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pins in order: request, busy enable, common request enable, latch control.
  task pins(input logic [3:0] exp);
    check({28'h000_0000, bus_request_out_n, busy_oe, common_request_line_oe, aen_n}, {28'h000_0000, exp});
  endtask : pins

  // Address phase held until ready, then data phase held until ready again.
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // One processor cycle: status settles, then a processor clock rise samples it.
  task proc(input logic [2:0] st);
    @(posedge clk);
    status_n <= st;
    repeat (4) @(posedge clk);
    pclk <= 1'b1;
    repeat (4) @(posedge clk);
    pclk <= 1'b0;
  endtask : proc

  // Arbiter actions happen on bus clock falls; give the synchronisers time.
  task falls(input int n);
    repeat (n) @(negedge bclk);
    repeat (10) @(posedge clk);
  endtask : falls

  task done_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, errors);
  endtask : done_test

  initial begin
    #100_000;
    errors++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    pins(4'h9);
    check({29'h000_0000, hresp, common_request_line_o, busy_o}, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    proc(3'h5);
    falls(2);
    pins(4'h9);
    check({31'h0000_0000, prio_out_n}, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    done_test("registers");
    falls(3);
    pins(4'h4);
    check({31'h0000_0000, prio_out_n}, 32'h0000_0001);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd & 32'h0000_0001, 32'h0000_0001);
    proc(3'h7);
    falls(3);
    pins(4'h4);
    want_lo <= 1'b1;
    falls(3);
    pins(4'h9);
    want_lo <= 1'b0;
    done_test("surrender");
    proc(3'h5);
    falls(3);
    pins(4'h4);
    lock_n <= 1'b0;
    want_hi <= 1'b1;
    falls(3);
    pins(4'h4);
    lock_n <= 1'b1;
    proc(3'h7);
    falls(3);
    pins(4'h9);
    proc(3'h5);
    falls(3);
    pins(4'h3);
    check({31'h0000_0000, prio_out_n}, 32'h0000_0001);
    init_n <= 1'b0;
    repeat (8) @(posedge clk);
    pins(4'h9);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd & 32'h0000_0010, 32'h0000_0010);
    want_hi <= 1'b0;
    proc(3'h7);
    init_n <= 1'b1;
    falls(2);
    pins(4'h9);
    done_test("lock and init");
    io_n <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      proc(c[2:0]);
      falls(2);
      pins(4'h9);
    end
    proc(3'h6);
    falls(3);
    pins(4'h4);
    proc(3'h1);
    want_lo <= 1'b1;
    falls(3);
    pins(4'h9);
    want_lo <= 1'b0;
    io_n <= 1'b1;
    proc(3'h7);
    done_test("io bus");
    resident <= 1'b1;
    proc(3'h5);
    falls(2);
    pins(4'h9);
    sel <= 1'b1;
    falls(3);
    pins(4'h4);
    sel <= 1'b0;
    want_lo <= 1'b1;
    falls(3);
    pins(4'h9);
    want_lo <= 1'b0;
    resident <= 1'b0;
    sel <= 1'b1;
    proc(3'h7);
    falls(2);
    pins(4'h9);
    done_test("resident");
    stop_test();
  end
endmodule : mbarb_top_tb
